// ### testbench/tb.sv
// self-checking bench for the counter timer capture channel
`include "capture_timer_params.svh"
module tb
  import capture_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // clock, reset and driven inputs
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en = 1'b0, one = 1'b0, swp = 1'b0, act = 1'b0;
  logic rld = 1'b0, sta = 1'b0, sto = 1'b0, capb = 1'b0;
  logic ce = 1'b1, ce_q = 1'b1; // clock enable and its value per edge
  logic [2:0] mode = 3'h0;
  scheme_t sch = SCHEME_UP;
  edge_t em = EDGE_RISE;
  logic [7:0] presc = 8'h00;
  logic [15:0] per = 16'h0004, wd = 16'h0000;
  logic [3:0] wr = 4'h0;
  // design outputs
  logic [15:0] tr, cnt, sa, sb, ba, bb;
  logic run_o, dir, ov, un, tc, ma, mb;
  // reference copy of the channel state
  logic [15:0] c, s_a, s_b, b_a, b_b;
  logic dn, run, pa, pb, ps, pt, prv, cap;
  int ph, p, w;
  int fails = 0, samples_checked = 0, cyc = 0;
  integer seed = 49;
  logic [20:0] q[$]; // expected events in order
  //////////////////////////////////////////////////////////////////////
  counter_timer_capture i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(ce),
    .enable_i(en), .mode_i(mode), .up_down_mode_i(sch),
    .one_shot_i(one), .slot_swap_on_match_bit_i(swp),
    .prescale_field_i(presc), .period_i(per),
    .trigger_source_select_a_i(16'h1000),
    .trigger_source_select_b_i(8'h02),
    .trigger_edge_select_i({2'h0, em, 8'hC0}), .tr_in_i(tr),
    .sw_reload_i(rld), .sw_start_i(sta), .sw_stop_i(sto),
    .software_capture_bits_i({capb, 1'b0}),
    .slot_wr_i(wr), .slot_wdata_i(wd),
    .count_o(cnt), .running_o(run_o), .dir_down_o(dir),
    .slot_a_compare_capture_o(sa), .slot_b_compare_capture_o(sb),
    .slot_a_buffer_o(ba), .slot_b_buffer_o(bb),
    .overflow_o(ov), .underflow_o(un), .terminal_count_event_o(tc),
    .slot_a_match_event_o(ma), .slot_b_match_event_o(mb)
  );
  trig_src_model i_src (.clk_i(clk_i), .act_i(act), .lines_o(tr));
  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7FFF) % n;
  endfunction
  task automatic cmp(input logic [95:0] e, g, input string m);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: %s exp %h got %h", $time, m, e, g);
    end
  endtask
  task automatic chk_ev(input logic [20:0] e);
    cmp(96'(e), 96'({ov, un, tc, ma, mb, cnt}), "event");
  endtask
  task automatic chk_st(input logic [81:0] e);
    cmp(96'(e), 96'({cnt, run_o, dir, sa, sb, ba, bb}), "state");
  endtask
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // short reset, asserted just after the falling edge
  task automatic reset_dut();
    #1;
    rst_b_i = 1'b0;
    {en, one, swp} = 3'h0;
    q.delete();
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    @(negedge clk_i);
  endtask
  task automatic put(input logic [3:0] m, input logic [15:0] d);
    wr = m;
    wd = d;
    @(negedge clk_i);
    wr = 4'h0;
    @(negedge clk_i); // idle edge so back-to-back writes stay apart
  endtask
  // reference for the coming rising edge, from the inputs as driven
  task automatic ref_edge();
    logic tk, det, o, u, m_a, m_b, t;
    tk = (ph == 0);
    ph = tk ? p : ph - 1;
    det = tr[2] != prv && (em == EDGE_BOTH || tr[2] == (em == EDGE_RISE));
    pa = (em == EDGE_BOTH) ? pa ^ det : pa | det; // merge
    pb = pb | capb;
    ps = ps | sto;
    pt = pt | sta;
    prv = tr[2];
    {o, u, m_a, m_b} = 4'h0;
    if (tk) begin // held to the tick
      if (cap && pa) begin // capture
        m_a = 1'b1;
        b_a = s_a;
        s_a = c;
      end
      if (cap && pb) begin
        m_b = 1'b1;
        b_b = s_b;
        s_b = c;
      end
      if (ps) begin // stop wins
        run = 1'b0;
      end else if (pt && !run) begin // resume
        run = 1'b1;
        if (!sch[1]) dn = (sch == SCHEME_DOWN);
      end else if (run) begin
        if (!cap) begin // compare on leaving
          m_a = (c == s_a);
          m_b = (c == s_b);
        end
        o = !dn && c == per; // wrap flags
        u = dn && c == 16'h0000;
        if (sch == SCHEME_UP && o) c = 16'h0000; // range
        else if (sch == SCHEME_DOWN && u) c = per;
        else if (o) c = per - 16'h0001;
        else if (u) c = 16'h0001;
        else c = dn ? c - 16'h0001 : c + 16'h0001;
        if (sch[1] && (o || u)) dn = o;
        if (one && (sch == SCHEME_UP ? o : u)) run = 1'b0;
        if (swp && !cap && m_a) {s_a, b_a} = {b_a, s_a}; // swap
        if (swp && !cap && m_b) {s_b, b_b} = {b_b, s_b};
      end
      {pa, pb, ps, pt} = 4'h0;
    end
    t = sch == SCHEME_UP ? o : sch == SCHEME_UPDN2 ? o | u : u;
    if (o | u | m_a | m_b) q.push_back({o, u, t, m_a, m_b, c});
    if (wr[0]) s_a = wd;
    if (wr[1]) s_b = wd;
  endtask
  //////////////////////////////////////////////////////////////////////
  // pulses hold while frozen, so only look after an enabled edge
  always @(posedge clk_i) ce_q <= ce;
  // oldest expectation against each event that shows
  always @(negedge clk_i) begin
    if (rst_b_i === 1'b1 && ce_q && {ov, un, tc, ma, mb} !== 5'h00) begin
      if (q.size() == 0) cmp(96'h0, 96'h1, "stray event");
      else chk_ev(q.pop_front());
    end
  end
  // hang guard, well above the roughly 610 cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      cmp(96'h0, 96'h1, "timeout");
      print_verdict();
    end
  end
  // main sequence: every scheme in timer then capture mode
  initial begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      reset_dut();
      chk_st(82'h0); // all state clear after reset
      sch = scheme_t'(k[1:0]); // scheme field
      cap = k[2];
      mode = cap ? `MODE_CAPTURE : `MODE_TIMER; // mode code
      per = 16'(2 + rnd(8));
      p = rnd(3);
      presc = 8'(p); // tick divider
      one = (k % 3 == 1); // single shot
      swp = k[1];
      em = edge_t'(2'(k % 3)); // capture edge kind
      put(4'h3, 16'hFFFF);
      put(4'hC, 16'(rnd(int'(per) + 1)));
      b_a = wd;
      b_b = wd;
      en = 1'b1; // enable after setup
      @(negedge clk_i);
      rld = 1'b1;
      w = 0;
      do begin
        @(negedge clk_i);
        rld = 1'b0;
        w++;
      end while (run_o !== 1'b1 && w < 8);
      c = sch == SCHEME_DOWN ? per : {15'h0000, sch[1]};
      dn = sch == SCHEME_DOWN;
      {run, pa, pb, ps, pt, prv} = 6'h20;
      ph = p;
      {s_a, s_b} = 32'hFFFFFFFF;
      chk_st({c, run, dn, s_a, s_b, b_a, b_b});
      for (int i = 0; i < 60; i++) begin
        wr = (i < 2) ? 4'(1 << i) : 4'h0;
        wd = (i == 0) ? 16'(rnd(int'(per) + 1)) : sch[0] ? 16'h0000 : per;
        sto = i > 4 && rnd(16) == 0;
        sta = i > 4 && rnd(8) == 0;
        capb = cap && i > 1 && rnd(5) == 0; // firmware capture
        act = i > 1;
        #1;
        ref_edge();
        @(negedge clk_i);
      end
      {wr, sto, sta, capb, act} = 8'h00;
      ce = 1'b0; // frozen edges must leave every state bit alone
      repeat (2) @(negedge clk_i);
      ce = 1'b1;
      mode = 3'h5; // unused mode code: channel idles
      repeat (2) @(negedge clk_i);
      #1;
      cmp(96'h0, 96'(q.size()), "missing event");
      chk_st({c, run, dn, s_a, s_b, b_a, b_b});
      $display("scenario %0d done", k);
    end
    print_verdict();
  end
endmodule

// ### testbench/trig_src_model.sv
// stand-in for the on-chip trigger sources feeding the channel
module trig_src_model (
  // clock and activity
  input wire logic clk_i,
  input wire logic act_i,
  // trigger lines toward the channel
  output logic [15:0] lines_o
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 49; // fixed seed, own stream
  //////////////////////////////////////////////////////////////////////
  // lines move just after a falling edge so the channel samples settled
  // levels; line 2 idles low so no stray edge is left after a reset
  initial lines_o = 16'h0000;
  always @(negedge clk_i) begin
    lines_o[15:3] <= lines_o[15:3] + 13'h0001; // unselected lines churn
    lines_o[1:0] <= ~lines_o[1:0];
    if (act_i) begin
      lines_o[2] <= 1'($random(seed)); // random capture edges
    end else begin
      lines_o[2] <= 1'b0; // released source reads low
    end
  end
endmodule

// ### verilog/capture_timer_params.svh
// constants for the counter timer capture channel
`ifndef CAPTURE_TIMER_PARAMS_SVH
`define CAPTURE_TIMER_PARAMS_SVH
`define CNT_W 16
`define MODE_TIMER 3'h0
`define MODE_CAPTURE 3'h2
`define COUNT_RST 16'h0000
`define SLOT_RST 16'h0000
`define PRESCALE_RST 8'h00
`define UPDN_START 16'h0001
`define SEL_W 4
`define EV_RELOAD 0
`define EV_START 1
`define EV_STOP 2
`define EV_COUNT 3
`define EV_CAP_A 4
`define EV_CAP_B 5
`define EV_NUM 6
`endif

// ### verilog/capture_timer_pkg.sv
// types shared by the counter timer capture channel
package capture_timer_pkg;
  // counting scheme codes
  typedef enum logic [1:0] {
    SCHEME_UP = 2'b00,
    SCHEME_DOWN = 2'b01,
    SCHEME_UPDN1 = 2'b10,
    SCHEME_UPDN2 = 2'b11
  } scheme_t;
  // trigger edge detection codes
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_PASS = 2'b11
  } edge_t;
endpackage

// ### verilog/counter_timer_capture.sv
// one counter channel in timer or capture mode
`include "capture_timer_params.svh"

module counter_timer_capture
  import capture_timer_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // configuration
  input wire logic enable_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] up_down_mode_i,
  input wire logic one_shot_i,
  input wire logic slot_swap_on_match_bit_i,
  input wire logic [7:0] prescale_field_i,
  input wire logic [15:0] period_i,
  // trigger selection
  input wire logic [15:0] trigger_source_select_a_i,
  input wire logic [7:0] trigger_source_select_b_i,
  input wire logic [11:0] trigger_edge_select_i,
  input wire logic [15:0] tr_in_i,
  // software commands, one-cycle pulses
  input wire logic sw_reload_i,
  input wire logic sw_start_i,
  input wire logic sw_stop_i,
  input wire logic [1:0] software_capture_bits_i,
  // software slot writes
  input wire logic [3:0] slot_wr_i,
  input wire logic [15:0] slot_wdata_i,
  // state
  output logic [15:0] count_o,
  output logic running_o,
  output logic dir_down_o,
  output logic [15:0] slot_a_compare_capture_o,
  output logic [15:0] slot_b_compare_capture_o,
  output logic [15:0] slot_a_buffer_o,
  output logic [15:0] slot_b_buffer_o,
  // events, one-cycle pulses
  output logic overflow_o,
  output logic underflow_o,
  output logic terminal_count_event_o,
  output logic slot_a_match_event_o,
  output logic slot_b_match_event_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // trigger index 0 is constant low, index 1 constant high
  function automatic logic pick(input logic [3:0] sel,
                                input logic [15:0] tr);
    logic v;
    v = 1'b0;
    if (sel == 4'h1) begin
      v = 1'b1;
    end else if (sel > 4'h1) begin
      v = tr[sel];
    end
    return v;
  endfunction

  // edge detection on a selected level
  function automatic logic detect(input logic [1:0] es,
                                  input logic lvl,
                                  input logic prv);
    logic d;
    d = 1'b0;
    case (es)
      EDGE_RISE: d = lvl & ~prv;
      EDGE_FALL: d = ~lvl & prv;
      EDGE_BOTH: d = lvl ^ prv;
      default: d = lvl;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescaler

  logic [7:0] pre_cnt; // counter clock divider
  logic tick; // active prescaled counter clock
  logic go; // tick while channel usable
  logic mode_ok; // timer or capture selected
  scheme_t scheme;

  assign scheme = scheme_t'(up_down_mode_i);
  assign mode_ok = (mode_i == `MODE_TIMER) ||
                   (mode_i == `MODE_CAPTURE);
  // divide by field plus one
  assign tick = clk_en_i && (pre_cnt == prescale_field_i);
  assign go = tick && enable_i && mode_ok;

  // prescale counter, held at zero while disabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt <= `PRESCALE_RST;
    end else if (clk_en_i) begin
      if (!enable_i || tick) begin
        pre_cnt <= `PRESCALE_RST;
      end else begin
        pre_cnt <= pre_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger selection and pending events

  logic [`EV_NUM-1:0] lvl; // selected trigger levels
  logic [`EV_NUM-1:0] prv; // levels one clock ago
  logic [`EV_NUM-1:0] det; // detections this clock
  logic [`EV_NUM-1:0] pend; // detections awaiting a tick
  logic [`EV_NUM-1:0] ev; // effective events at the tick
  logic [`EV_NUM-1:0] sw; // software commands

  assign lvl[`EV_RELOAD] = pick(trigger_source_select_a_i[3:0], tr_in_i);
  assign lvl[`EV_START] = pick(trigger_source_select_a_i[7:4], tr_in_i);
  assign lvl[`EV_STOP] = pick(trigger_source_select_a_i[11:8], tr_in_i);
  assign lvl[`EV_COUNT] = pick(trigger_source_select_a_i[15:12], tr_in_i);
  assign lvl[`EV_CAP_A] = pick(trigger_source_select_b_i[3:0], tr_in_i);
  assign lvl[`EV_CAP_B] = pick(trigger_source_select_b_i[7:4], tr_in_i);
  assign sw = {software_capture_bits_i, 1'b0, sw_stop_i, sw_start_i,
               sw_reload_i};

  // per event detection, pending and merge
  always_comb begin
    for (int i = 0; i < `EV_NUM; i++) begin
      det[i] = detect(trigger_edge_select_i[2*i +: 2], lvl[i], prv[i]);
      if (trigger_edge_select_i[2*i +: 2] == EDGE_PASS) begin
        ev[i] = lvl[i] | sw[i]; // level acts as sampled
      end else if (trigger_edge_select_i[2*i +: 2] == EDGE_BOTH) begin
        ev[i] = pend[i] ^ det[i] | sw[i];
      end else begin
        ev[i] = pend[i] | det[i] | sw[i];
      end
    end
  end

  // previous levels for the edge detectors
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prv <= '0;
    end else if (clk_en_i) begin
      prv <= lvl;
    end
  end

  // events wait for the next tick; a tick consumes them
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= '0;
    end else if (clk_en_i) begin
      for (int i = 0; i < `EV_NUM; i++) begin
        if (tick) begin
          pend[i] <= 1'b0;
        end else if (trigger_edge_select_i[2*i +: 2] == EDGE_BOTH) begin
          // even count cancels; a firmware pulse is not lost to an edge in the same clock
          pend[i] <= (pend[i] ^ det[i]) | sw[i];
        end else begin
          pend[i] <= (pend[i] | det[i] | sw[i]) &
                     (trigger_edge_select_i[2*i +: 2] != EDGE_PASS);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter next state

  logic [15:0] count; // current count
  logic running; // counter runs
  logic dir_down; // current direction
  logic [15:0] next_count;
  logic next_running;
  logic next_dir_down;
  logic step; // count event while running
  logic ov; // overflow this tick
  logic un; // underflow this tick
  logic tc; // terminal count this tick
  logic cap_mode; // capture mode selected
  logic [1:0] cap_go; // captures acted on
  logic [1:0] match; // slot match events

  assign cap_mode = (mode_i == `MODE_CAPTURE);
  assign cap_go = {2{go && cap_mode}} & ev[`EV_CAP_B:`EV_CAP_A];

  // reload, stop, start, step in priority order
  always_comb begin
    next_count = count;
    next_running = running;
    next_dir_down = dir_down;
    step = 1'b0;
    ov = 1'b0;
    un = 1'b0;
    if (go && ev[`EV_RELOAD]) begin
      next_running = 1'b1;
      case (scheme)
        SCHEME_UP: begin
          next_count = `COUNT_RST;
          next_dir_down = 1'b0;
        end
        SCHEME_DOWN: begin
          next_count = period_i;
          next_dir_down = 1'b1;
        end
        default: begin
          next_count = `UPDN_START;
          next_dir_down = 1'b0;
        end
      endcase
    end else if (go && ev[`EV_STOP]) begin
      next_running = 1'b0;
    end else if (go) begin
      if (ev[`EV_START] && !running) begin
        next_running = 1'b1; // no count init
        if (scheme == SCHEME_UP) begin
          next_dir_down = 1'b0;
        end else if (scheme == SCHEME_DOWN) begin
          next_dir_down = 1'b1;
        end
      end
      step = running && ev[`EV_COUNT];
      if (step && !dir_down) begin
        if (count == period_i) begin
          ov = 1'b1;
          if (scheme == SCHEME_UP) begin
            next_count = `COUNT_RST;
          end else begin
            next_count = 16'(period_i - 16'h0001); // turn down
            next_dir_down = 1'b1;
          end
        end else begin
          next_count = 16'(count + 16'h0001);
        end
      end else if (step) begin
        if (count == 16'h0000) begin
          un = 1'b1;
          if (scheme == SCHEME_DOWN) begin
            next_count = period_i;
          end else begin
            next_count = `UPDN_START; // turn up
            next_dir_down = 1'b0;
          end
        end else begin
          next_count = 16'(count - 16'h0001);
        end
      end
      // single shot ends one period: up on ov, others on un
      if (one_shot_i && ((scheme == SCHEME_UP) ? ov : un)) begin
        next_running = 1'b0;
      end
    end
  end

  // terminal count by scheme, only from stepping
  always_comb begin
    case (scheme)
      SCHEME_UP: tc = ov;
      SCHEME_UPDN2: tc = ov | un;
      default: tc = un;
    endcase
  end

  // match on leaving a slot value, or on capture
  assign match[0] = cap_mode ? cap_go[0] :
                    (step && count == slot_a_compare_capture_o);
  assign match[1] = cap_mode ? cap_go[1] :
                    (step && count == slot_b_compare_capture_o);

  // counter state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= `COUNT_RST;
      running <= 1'b0;
      dir_down <= 1'b0;
    end else if (clk_en_i) begin
      count <= next_count;
      running <= next_running && enable_i;
      dir_down <= next_dir_down;
    end
  end

  // registered event pulses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
      terminal_count_event_o <= 1'b0;
      slot_a_match_event_o <= 1'b0;
      slot_b_match_event_o <= 1'b0;
    end else if (clk_en_i) begin
      overflow_o <= ov;
      underflow_o <= un;
      terminal_count_event_o <= tc;
      slot_a_match_event_o <= match[0];
      slot_b_match_event_o <= match[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare/capture slots and buffers

  // capture and swap share one clock so the buffer gets the old slot
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slot_a_compare_capture_o <= `SLOT_RST;
      slot_a_buffer_o <= `SLOT_RST;
    end else if (clk_en_i) begin
      if (cap_go[0]) begin
        slot_a_compare_capture_o <= count;
        slot_a_buffer_o <= slot_a_compare_capture_o;
      end else if (match[0] && slot_swap_on_match_bit_i) begin
        slot_a_compare_capture_o <= slot_a_buffer_o;
        slot_a_buffer_o <= slot_a_compare_capture_o;
      end else begin
        if (slot_wr_i[0]) slot_a_compare_capture_o <= slot_wdata_i;
        if (slot_wr_i[2]) slot_a_buffer_o <= slot_wdata_i;
      end
    end
  end

  // second slot, same scheme
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slot_b_compare_capture_o <= `SLOT_RST;
      slot_b_buffer_o <= `SLOT_RST;
    end else if (clk_en_i) begin
      if (cap_go[1]) begin
        slot_b_compare_capture_o <= count;
        slot_b_buffer_o <= slot_b_compare_capture_o;
      end else if (match[1] && slot_swap_on_match_bit_i) begin
        slot_b_compare_capture_o <= slot_b_buffer_o;
        slot_b_buffer_o <= slot_b_compare_capture_o;
      end else begin
        if (slot_wr_i[1]) slot_b_compare_capture_o <= slot_wdata_i;
        if (slot_wr_i[3]) slot_b_buffer_o <= slot_wdata_i;
      end
    end
  end

  assign count_o = count;
  assign running_o = running;
  assign dir_down_o = dir_down;

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_RELOAD_UPDN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    go && ev[`EV_RELOAD] && scheme[1] |=> count == 16'h0001 && running)
    else $error("updn reload not 1");
  AST_OV_LEAVE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step && !dir_down && count == period_i && !ev[`EV_RELOAD]
    |=> overflow_o && terminal_count_event_o ==
    (scheme == SCHEME_UP || scheme == SCHEME_UPDN2))
    else $error("overflow or tc wrong");
  AST_UN_TC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(underflow_o) |-> terminal_count_event_o)
    else $error("underflow without tc");
  AST_RELOAD_NO_TC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    go && ev[`EV_RELOAD] |=> !terminal_count_event_o)
    else $error("reload raised tc");
  AST_CAP_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cap_go[0] && clk_en_i |=> slot_a_compare_capture_o == $past(count)
    && slot_a_buffer_o == $past(slot_a_compare_capture_o))
    else $error("capture a load wrong");
  AST_CAP_MATCH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cap_go[1] |=> slot_b_match_event_o)
    else $error("capture b no match");
  AST_STOP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    go && ev[`EV_STOP] && !ev[`EV_RELOAD] |=> !running ##1
    $stable(count) || !clk_en_i || $past(go && ev[`EV_RELOAD]))
    else $error("stop did not halt");
  AST_START_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    go && ev[`EV_START] && !running && !ev[`EV_RELOAD] && !ev[`EV_STOP]
    |=> running && count == $past(count))
    else $error("start changed count");
  AST_ONE_SHOT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    go && one_shot_i && cap_mode && un && scheme != SCHEME_UP
    |=> !running)
    else $error("single shot kept running");

endmodule
